// ---- appc_capture_model.sv ----
// Purpose: Downstream capture logic for the sample stream
// Assumes: mode 0 prompt, 1 random stalls, 2 stalled
// Notes: Flags any word that changes while held by a stall
`timescale 1ns/1ps
module appc_capture_model (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [1:0] mode,
   input wire logic out_valid,
   input wire logic out_enable,
   input wire logic [13:0] out_data,
   output logic out_ready,
   output int accepted,
   output int hold_errs
);
   logic [15:0] lf;
   logic [13:0] last;
   logic waiting;
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         lf <= 16'h0001;
         out_ready <= 1'b1;
         accepted <= 0;
         hold_errs <= 0;
         waiting <= 1'b0;
         last <= 14'h0;
      end else begin
         if (waiting && (out_valid !== 1'b1 || out_data !== last)) hold_errs <= hold_errs + 1;
         // A word withdrawn by full sleep is not a hold fault
         waiting <= out_valid && !out_ready && out_enable;
         last <= out_data;
         if (out_valid && out_ready) accepted <= accepted + 1;
         lf <= {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
         out_ready <= mode == 2'd0 || (mode == 2'd1 && lf[0]);
      end
   end
endmodule

// ---- appc_defines.svh ----
// Purpose: Constants for the converter post-processing control block
// Assumes: 100 MHz sys_clk, APB with 32-bit data
// Notes: Offsets are byte addresses
`ifndef APPC_DEFINES_SVH
`define APPC_DEFINES_SVH
`define APPC_DW 14
`define APPC_BYPASS_LAT 10
`define APPC_PROC_LAT 13
`define APPC_OFS_CTRL 12'h000
`define APPC_OFS_GAIN 12'h004
`define APPC_OFS_DCTRIM 12'h008
`define APPC_OFS_POWER 12'h00c
`define APPC_OFS_STATUS 12'h010
`define APPC_CTRL_FAST_DIS 0
`define APPC_DC_EN 0
`define APPC_DC_HOLD 1
`define APPC_DC_SPEED_LSB 4
`define APPC_PWR_FULL 0
`define APPC_PWR_CORE 1
`define APPC_GAIN_MAX 4'hc
`define APPC_SPEED_MAX 4'hb
`define APPC_FULL_WAKE_US 100
`define APPC_CORE_WAKE_US 5
`define APPC_CLK_MHZ 100
`define APPC_FULL_WAKE_CYC (`APPC_FULL_WAKE_US * `APPC_CLK_MHZ)
`define APPC_CORE_WAKE_CYC (`APPC_CORE_WAKE_US * `APPC_CLK_MHZ)
`define APPC_SPEED_BASE_LOG2 20
`define APPC_ACC_FRAC 32
`endif

// ---- appc_pkg.sv ----
// Purpose: Types for the post-processing control block
// Assumes: Constants come from appc_defines.svh
// Notes: None
`include "appc_defines.svh"
package appc_pkg;
   typedef logic signed [`APPC_DW-1:0] appc_sample_t;
   typedef enum logic [1:0] {
      APPC_RUN = 2'b00,
      APPC_SLEEP = 2'b01,
      APPC_WAKE = 2'b10
   } appc_pwr_t;
endpackage

// ---- appc_skid.sv ----
// Purpose: Two-entry buffer in the sample path
// Assumes: Same clock as producer and consumer
// Notes: Ready to the producer falls only when both entries are full
`timescale 1ns/1ps
module appc_skid (
   input wire logic clk,
   input wire logic rst_n,
   appc_stream_if.snk in_s,
   appc_stream_if.src out_s
);
   logic [13:0] mem [0:1];
   logic [13:0] next_mem [0:1];
   logic wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [1:0] count, next_count;
   logic push, pop;
   assign in_s.ready = (count != 2'h2);
   assign out_s.valid = (count != 2'h0);
   assign out_s.data = mem[rd_ptr];
   always_comb begin
      push = in_s.valid && in_s.ready;
      pop = out_s.valid && out_s.ready;
      next_mem[0] = mem[0];
      next_mem[1] = mem[1];
      if (push) begin
         next_mem[wr_ptr] = in_s.data;
      end
      next_wr_ptr = wr_ptr ^ push;
      next_rd_ptr = rd_ptr ^ pop;
      next_count = count + {1'b0, push} - {1'b0, pop};
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem[0] <= 14'h0000;
         mem[1] <= 14'h0000;
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'h0;
      end else begin
         mem[0] <= next_mem[0];
         mem[1] <= next_mem[1];
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end
endmodule

// ---- appc_stream_if.sv ----
// Purpose: Valid/ready sample stream between buffer and top
// Assumes: One clock domain
// Notes: None
`timescale 1ns/1ps
interface appc_stream_if;
   logic valid;
   logic ready;
   logic [13:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ---- appc_top.sv ----
// Purpose: Bypass, gain, dc trim and sleep control behind the converter core
// Assumes: Raw samples arrive one per sys_clk from logic on the same clock
// Notes: Twos complement samples; APB slave with one wait state
//
// Functional notes
// - Bypass path delays raw samples exactly ten cycles
// - Reset selects bypass, gain and trim off
// - Processing path adds pipeline cycles beyond bypass
// - Bypass left only while fast_path_disable is one
// - Gain codes 0 to 6 dB, half-dB steps
// - Leaving bypass applies 0 dB until programmed
// - Gain scales full-scale span per table
// - Enabled loop estimates, subtracts offset each cycle
// - dc_trim_enable turns correction on, resets off
// - Loop speed code sets constant, reserved ignored
// - Hold freezes estimate, keeps applying it
// - Full sleep, core sleep, buffer disable supported; no separate buffer disable here, outputs are released only in full sleep
// - Full sleep powers down, outputs high impedance
// - Full sleep exit: data valid after 100 us
// - Core sleep: references kept, 5 us wake
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
`include "appc_defines.svh"
module appc_top #(
   parameter int unsigned FULL_WAKE_CYC = `APPC_FULL_WAKE_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [13:0] raw_sample,
   input wire logic out_ready,
   output logic [13:0] out_data,
   output logic out_valid,
   output logic out_enable,
   output logic core_power_down,
   output logic ref_power_down
);
   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   logic rst_s1, rst_s2;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1 <= 1'b0;
         rst_s2 <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_s2 <= rst_s1;
      end
   end
   wire logic srst_n = rst_s2;

   // ------------------------------------------------------------
   // Registers and APB slave
   // ------------------------------------------------------------
   logic fast_path_disable, next_fast_path_disable;
   logic [3:0] gain_code, next_gain_code;
   logic dc_trim_enable, next_dc_trim_enable;
   logic dc_trim_hold, next_dc_trim_hold;
   logic [3:0] dc_trim_loop_speed, next_dc_trim_loop_speed;
   logic full_sleep_request, next_full_sleep_request;
   logic core_sleep_request, next_core_sleep_request;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr;
   logic [31:0] status_word;
   appc_pkg::appc_pwr_t pwr_state, next_pwr_state;
   logic data_live;
   logic wr_en, rd_en, bad_addr;

   always_comb begin
      wr_en = psel && penable && pwrite && pready;
      rd_en = psel && penable && !pwrite && !pready;
      bad_addr = 1'b0;
      next_fast_path_disable = fast_path_disable;
      next_gain_code = gain_code;
      next_dc_trim_enable = dc_trim_enable;
      next_dc_trim_hold = dc_trim_hold;
      next_dc_trim_loop_speed = dc_trim_loop_speed;
      next_full_sleep_request = full_sleep_request;
      next_core_sleep_request = core_sleep_request;
      next_prdata = 32'h0000_0000;
      next_pready = psel && penable && !pready;
      next_pslverr = 1'b0;
      status_word = {29'h0, data_live, pwr_state};
      unique case (paddr)
         `APPC_OFS_CTRL: begin
            next_prdata = {31'h0, fast_path_disable};
            if (wr_en && pstrb[0]) begin
               next_fast_path_disable = pwdata[`APPC_CTRL_FAST_DIS];
            end
         end
         `APPC_OFS_GAIN: begin
            next_prdata = {28'h0, gain_code};
            // Codes above 6 dB ignored, keep last legal gain
            if (wr_en && pstrb[0] && pwdata[3:0] <= `APPC_GAIN_MAX) begin
               next_gain_code = pwdata[3:0];
            end
         end
         `APPC_OFS_DCTRIM: begin
            next_prdata = {24'h0, dc_trim_loop_speed, 2'h0, dc_trim_hold, dc_trim_enable};
            if (wr_en && pstrb[0]) begin
               next_dc_trim_enable = pwdata[`APPC_DC_EN];
               next_dc_trim_hold = pwdata[`APPC_DC_HOLD];
               if (pwdata[`APPC_DC_SPEED_LSB+3:`APPC_DC_SPEED_LSB] <= `APPC_SPEED_MAX) begin
                  next_dc_trim_loop_speed = pwdata[`APPC_DC_SPEED_LSB+3:`APPC_DC_SPEED_LSB];
               end
            end
         end
         `APPC_OFS_POWER: begin
            next_prdata = {30'h0, core_sleep_request, full_sleep_request};
            if (wr_en && pstrb[0]) begin
               next_full_sleep_request = pwdata[`APPC_PWR_FULL];
               next_core_sleep_request = pwdata[`APPC_PWR_CORE];
            end
         end
         `APPC_OFS_STATUS: begin
            next_prdata = status_word;
         end
         default: begin
            bad_addr = 1'b1;
         end
      endcase
      if (!rd_en) begin
         next_prdata = 32'h0000_0000;
      end
      next_pslverr = next_pready && bad_addr;
   end

   always_ff @(posedge sys_clk or negedge srst_n) begin
      if (!srst_n) begin
         fast_path_disable <= 1'b0;
         gain_code <= 4'h0;
         dc_trim_enable <= 1'b0;
         dc_trim_hold <= 1'b0;
         dc_trim_loop_speed <= 4'h0;
         full_sleep_request <= 1'b0;
         core_sleep_request <= 1'b0;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         fast_path_disable <= next_fast_path_disable;
         gain_code <= next_gain_code;
         dc_trim_enable <= next_dc_trim_enable;
         dc_trim_hold <= next_dc_trim_hold;
         dc_trim_loop_speed <= next_dc_trim_loop_speed;
         full_sleep_request <= next_full_sleep_request;
         core_sleep_request <= next_core_sleep_request;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // ------------------------------------------------------------
   // Power state
   // ------------------------------------------------------------
   logic [13:0] wake_cnt, next_wake_cnt;
   logic next_core_pd, next_ref_pd, next_out_enable;
   always_comb begin
      next_pwr_state = pwr_state;
      next_wake_cnt = wake_cnt;
      unique case (pwr_state)
         appc_pkg::APPC_RUN: begin
            if (full_sleep_request || core_sleep_request) begin
               next_pwr_state = appc_pkg::APPC_SLEEP;
            end
         end
         appc_pkg::APPC_SLEEP: begin
            if (!full_sleep_request && !core_sleep_request) begin
               next_pwr_state = appc_pkg::APPC_WAKE;
               // Full sleep also lost the references, so the long wait
               next_wake_cnt = ref_power_down ? 14'(FULL_WAKE_CYC - 1) : 14'(`APPC_CORE_WAKE_CYC - 1);
            end
         end
         appc_pkg::APPC_WAKE: begin
            if (full_sleep_request || core_sleep_request) begin
               next_pwr_state = appc_pkg::APPC_SLEEP;
            end else if (wake_cnt == 14'h0000) begin
               next_pwr_state = appc_pkg::APPC_RUN;
            end else begin
               next_wake_cnt = wake_cnt - 14'h0001;
            end
         end
         default: begin
            next_pwr_state = appc_pkg::APPC_RUN;
         end
      endcase
      next_core_pd = full_sleep_request || core_sleep_request;
      next_ref_pd = full_sleep_request || (ref_power_down && pwr_state != appc_pkg::APPC_RUN && core_sleep_request);
      next_out_enable = !full_sleep_request;
   end
   always_ff @(posedge sys_clk or negedge srst_n) begin
      if (!srst_n) begin
         pwr_state <= appc_pkg::APPC_RUN;
         wake_cnt <= 14'h0000;
         core_power_down <= 1'b0;
         ref_power_down <= 1'b0;
         out_enable <= 1'b1;
      end else begin
         pwr_state <= next_pwr_state;
         wake_cnt <= next_wake_cnt;
         core_power_down <= next_core_pd;
         ref_power_down <= next_ref_pd;
         out_enable <= next_out_enable;
      end
   end
   assign data_live = (pwr_state == appc_pkg::APPC_RUN);

   // ------------------------------------------------------------
   // Sample pipeline
   // ------------------------------------------------------------
   // Bypass: 8 stages, buffer entry and output register make 10; processing adds 3
   localparam int BYP = `APPC_BYPASS_LAT - 2;
   logic [13:0] dly [0:BYP-1];
   logic [13:0] next_dly [0:BYP-1];
   logic signed [13:0] gained, next_gained;
   logic signed [13:0] trimmed, next_trimmed;
   logic signed [13:0] proc_out, next_proc_out;
   logic signed [45:0] est, next_est;
   logic signed [17:0] mult_p;
   logic [15:0] gain_mult;
   logic signed [31:0] scaled;
   logic signed [45:0] err_ext;
   logic [5:0] shift;
   logic signed [13:0] est_int;

   // Gain multipliers, Q1.15 of full-scale ratio
   function automatic logic [15:0] gain_lut(input logic [3:0] code);
      logic [15:0] g;
      g = 16'h8000;
      unique case (code)
         4'h0: g = 16'h8000;
         4'h1: g = 16'h878c;
         4'h2: g = 16'h8f9e;
         4'h3: g = 16'h9838;
         4'h4: g = 16'ha124;
         4'h5: g = 16'haa25;
         4'h6: g = 16'hb43e;
         4'h7: g = 16'hbe62;
         4'h8: g = 16'hc9a3;
         4'h9: g = 16'hd56b;
         4'ha: g = 16'he1f3;
         4'hb: g = 16'hef2b;
         4'hc: g = 16'hffff;
         default: g = 16'h8000;
      endcase
      return g;
   endfunction

   genvar gi;
   generate
      for (gi = 0; gi < BYP; gi++) begin : g_dly
         if (gi == 0) begin : g_first
            assign next_dly[gi] = raw_sample;
         end else begin : g_rest
            assign next_dly[gi] = dly[gi-1];
         end
      end
   endgenerate

   always_comb begin
      gain_mult = gain_lut(fast_path_disable ? gain_code : 4'h0);
      scaled = $signed(dly[BYP-1]) * $signed({1'b0, gain_mult});
      // Clip rather than wrap when gain pushes past full scale
      if (scaled > 32'sh0fff_8000) begin
         next_gained = 14'sh1fff;
      end else if (scaled < -32'sh1000_0000) begin
         next_gained = -14'sh2000;
      end else begin
         next_gained = 14'(scaled >>> 15);
      end
      est_int = 14'(est >>> `APPC_ACC_FRAC);
      mult_p = 18'(gained) - 18'(dc_trim_enable ? est_int : 14'sh0000);
      if (mult_p > 18'sh01fff) begin
         next_trimmed = 14'sh1fff;
      end else if (mult_p < -18'sh02000) begin
         next_trimmed = -14'sh2000;
      end else begin
         next_trimmed = 14'(mult_p);
      end
      shift = 6'(`APPC_SPEED_BASE_LOG2) + {2'b00, dc_trim_loop_speed};
      err_ext = $signed({gained, 32'h0000_0000}) - est;
      next_est = est;
      if (!dc_trim_enable) begin
         next_est = 46'sh0;
      end else if (!dc_trim_hold) begin
         next_est = est + (err_ext >>> shift);
      end
      next_proc_out = trimmed;
   end

   // ------------------------------------------------------------
   // Output select and buffer
   // ------------------------------------------------------------
   appc_stream_if buf_in ();
   appc_stream_if buf_out ();
   logic [13:0] sel_data;
   logic [13:0] next_out_data;
   logic next_out_valid;
   always_comb begin
      sel_data = fast_path_disable ? proc_out : dly[BYP-1];
      buf_in.valid = data_live && out_enable;
      buf_in.data = sel_data;
      buf_out.ready = out_ready || !out_valid;
      next_out_valid = out_valid;
      next_out_data = out_data;
      if (buf_out.ready) begin
         next_out_valid = buf_out.valid;
         next_out_data = buf_out.valid ? buf_out.data : out_data;
      end
      if (!out_enable) begin
         next_out_valid = 1'b0;
      end
   end

   appc_skid u_skid (
      .clk(sys_clk),
      .rst_n(srst_n),
      .in_s(buf_in),
      .out_s(buf_out)
   );

   always_ff @(posedge sys_clk or negedge srst_n) begin
      if (!srst_n) begin
         for (int i = 0; i < BYP; i++) begin
            dly[i] <= 14'h0000;
         end
         gained <= 14'sh0000;
         trimmed <= 14'sh0000;
         proc_out <= 14'sh0000;
         est <= 46'sh0;
         out_data <= 14'h0000;
         out_valid <= 1'b0;
      end else begin
         for (int i = 0; i < BYP; i++) begin
            dly[i] <= next_dly[i];
         end
         gained <= next_gained;
         trimmed <= next_trimmed;
         proc_out <= next_proc_out;
         est <= next_est;
         out_data <= next_out_data;
         out_valid <= next_out_valid;
      end
   end
endmodule

// ---- appc_top_properties.sv ----
// Purpose: Port assertions for appc_top
// Assumes: One clock domain, APB writes tracked from the bus itself
// Notes: Latency checks only hold before any stall or sleep, as buffer fill changes latency
`timescale 1ns/1ps
module appc_top_properties #(
   parameter int unsigned FULL_WAKE_CYC = 20
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [13:0] raw_sample,
   input wire logic out_ready,
   input wire logic [13:0] out_data,
   input wire logic out_valid,
   input wire logic out_enable,
   input wire logic core_power_down,
   input wire logic ref_power_down
);
   logic wr, fast, gain_on, trim_on, dirty, clean;
   logic [7:0] age;
   assign wr = psel && penable && pready && pwrite && pstrb[0];
   assign clean = !dirty && age >= 8'd40 && !trim_on && !gain_on;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         fast <= 1'b0;
         gain_on <= 1'b0;
         trim_on <= 1'b0;
         dirty <= 1'b0;
         age <= 8'h00;
      end else begin
         age <= wr ? 8'h00 : (age == 8'hff ? age : age + 8'h01);
         if (wr && paddr == 12'h000) fast <= pwdata[0];
         if (wr && paddr == 12'h004 && pwdata[3:0] <= 4'hc) gain_on <= pwdata[3:0] != 4'h0;
         if (wr && paddr == 12'h008) trim_on <= pwdata[0];
         if (!out_ready || (wr && paddr == 12'h00c && pwdata[1:0] != 2'b00)) dirty <= 1'b1;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   property p_reset_defaults;
      $rose(rst_n) |-> out_enable && !core_power_down && !ref_power_down && !out_valid;
   endproperty
   a_reset_defaults: assert property (p_reset_defaults) else $error("reset outputs wrong");
   property p_bypass_latency;
      clean && !fast |-> out_valid && out_data == $past(raw_sample, 10);
   endproperty
   a_bypass_latency: assert property (p_bypass_latency) else $error("bypass latency wrong");
   property p_proc_latency;
      clean && fast |-> out_valid && out_data == $past(raw_sample, 13);
   endproperty
   a_proc_latency: assert property (p_proc_latency) else $error("processing latency wrong");
   property p_full_sleep_entry;
      wr && paddr == 12'h00c && pwdata[0] |-> ##[1:3] !out_enable && ref_power_down && core_power_down;
   endproperty
   a_full_sleep_entry: assert property (p_full_sleep_entry) else $error("full sleep not entered");
   property p_core_sleep_entry;
      wr && paddr == 12'h00c && pwdata[1:0] == 2'b10 |-> ##[1:3] core_power_down && !ref_power_down && out_enable;
   endproperty
   a_core_sleep_entry: assert property (p_core_sleep_entry) else $error("core sleep wrong");
   property p_sleep_hiz;
      ref_power_down |-> !out_enable;
   endproperty
   a_sleep_hiz: assert property (p_sleep_hiz) else $error("outputs driven in full sleep");
   property p_full_has_core;
      ref_power_down |-> core_power_down;
   endproperty
   a_full_has_core: assert property (p_full_has_core) else $error("core awake in full sleep");
   property p_hiz_cause;
      $fell(out_enable) |-> ref_power_down;
   endproperty
   a_hiz_cause: assert property (p_hiz_cause) else $error("outputs released without sleep");
endmodule

// ---- testbench.sv ----
// Purpose: Self-checking bench for appc_top
// Assumes: Full sleep wake count shortened to 20 cycles, core sleep wake kept at its full count
// Notes: Samples come from an LFSR; a history queue is the reference
`timescale 1ns/1ps
`include "appc_defines.svh"
module testbench;
   localparam int unsigned WAKE = 20;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hf;
   logic [13:0] raw_sample = 14'h0;
   logic [1:0] mode = 2'd0;
   logic dc_on = 1'b0;
   logic [15:0] seed = 16'h0001;
   logic [31:0] prdata, rd, exp_spd;
   logic pready, pslverr, out_ready, out_valid, out_enable, core_power_down, ref_power_down, err;
   logic [13:0] out_data;
   int accepted, hold_errs, num_errors = 0, total_checks = 0, cyc = 0, t0, q[$];
   always #5 sys_clk = ~sys_clk;
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      seed <= lfsr(seed);
      raw_sample <= dc_on ? 14'h1f00 : seed[13:0];
      q.push_front(int'($signed(raw_sample)));
      if (q.size() > 32) void'(q.pop_back());
   end
   appc_top #(.FULL_WAKE_CYC(WAKE)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .raw_sample(raw_sample), .out_ready(out_ready), .out_data(out_data),
      .out_valid(out_valid), .out_enable(out_enable), .core_power_down(core_power_down),
      .ref_power_down(ref_power_down));
   appc_capture_model u_cap (.sys_clk(sys_clk), .rst_n(rst_n), .mode(mode), .out_valid(out_valid),
      .out_data(out_data), .out_ready(out_ready), .accepted(accepted), .hold_errs(hold_errs), .out_enable(out_enable));
   // ----------------
   // Tasks
   // ----------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) num_errors++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
      apb(1'b0, a, 32'h0);
      check("prdata", rd, exp);
      check("pslverr", {31'h0, err}, {31'h0, eerr});
   endtask
   task automatic lat(input int l, input int g, input int cnt);
      real e;
      int t, d;
      repeat (cnt) begin
         @(posedge sys_clk);
         #1;
         e = q[l-1] * 10.0 ** (g / 40.0);
         if (e > 8191.0) e = 8191.0;
         if (e < -8192.0) e = -8192.0;
         t = 2 + int'(e < 0.0 ? -e : e) / 64;
         d = int'($signed(out_data)) - int'(e);
         check("out_valid", {31'h0, out_valid}, 32'h1);
         if (g == 0) check("out_data", {18'h0, out_data}, {18'h0, 14'(q[l-1])});
         else check("gain", {31'h0, d <= t && d >= -t}, 32'h1);
      end
   endtask
   task automatic wake(input int lo);
      t0 = cyc;
      apb(1'b1, 12'h00c, 32'h0);
      do apb(1'b0, 12'h010, 32'h0); while (rd[2:0] !== 3'b100 && cyc - t0 < 2000);
      check("wake", {31'h0, cyc - t0 >= lo && cyc - t0 < lo + 40}, 32'h1);
   endtask
   // ----------------
   // Scenarios
   // ----------------
   initial begin
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rdchk(12'h000, 32'h0, 1'b0);
      rdchk(12'h004, 32'h0, 1'b0);
      rdchk(12'h008, 32'h0, 1'b0);
      rdchk(12'h00c, 32'h0, 1'b0);
      rdchk(12'h010, 32'h4, 1'b0);
      rdchk(12'h014, 32'h0, 1'b1);
      repeat (40) @(posedge sys_clk);
      lat(`APPC_BYPASS_LAT, 0, 16);
      apb(1'b1, 12'h004, 32'hc);
      repeat (30) @(posedge sys_clk);
      lat(`APPC_BYPASS_LAT, 0, 8);
      apb(1'b1, 12'h004, 32'h0);
      pstrb <= 4'h0;
      apb(1'b1, 12'h000, 32'h1);
      pstrb <= 4'hf;
      rdchk(12'h000, 32'h0, 1'b0);
      apb(1'b1, 12'h000, 32'h1);
      rdchk(12'h000, 32'h1, 1'b0);
      repeat (40) @(posedge sys_clk);
      lat(`APPC_PROC_LAT, 0, 16);
      for (int g = 0; g <= 12; g++) begin
         apb(1'b1, 12'h004, 32'(g));
         repeat (30) @(posedge sys_clk);
         lat(`APPC_PROC_LAT, g, 6);
      end
      apb(1'b1, 12'h004, 32'hd);
      rdchk(12'h004, 32'hc, 1'b0);
      apb(1'b1, 12'h004, 32'h0);
      exp_spd = 32'h0;
      for (int c = 0; c < 16; c++) begin
         apb(1'b1, 12'h008, {24'h0, 4'(c), 4'h3});
         if (c <= 11) exp_spd = 32'(c);
         rdchk(12'h008, {24'h0, exp_spd[3:0], 4'h3}, 1'b0);
      end
      repeat (40) @(posedge sys_clk);
      lat(`APPC_PROC_LAT, 0, 16);
      // Constant input so the slow loop builds a visible estimate
      dc_on <= 1'b1;
      apb(1'b1, 12'h008, 32'h1);
      repeat (1500) @(posedge sys_clk);
      apb(1'b1, 12'h008, 32'h3);
      repeat (20) @(posedge sys_clk);
      exp_spd = {18'h0, out_data};
      check("trim", {31'h0, out_data < 14'h1efc}, 32'h1);
      repeat (20) @(posedge sys_clk);
      check("held", {18'h0, out_data}, exp_spd);
      apb(1'b1, 12'h008, 32'h1);
      repeat (20) @(posedge sys_clk);
      check("resumed", {31'h0, out_data <= exp_spd[13:0]}, 32'h1);
      dc_on <= 1'b0;
      apb(1'b1, 12'h008, 32'h0);
      // Random stalls, then a full stall to fill the buffer
      mode <= 2'd1;
      repeat (200) @(posedge sys_clk);
      mode <= 2'd2;
      repeat (20) @(posedge sys_clk);
      check("stall valid", {31'h0, out_valid}, 32'h1);
      apb(1'b1, 12'h00c, 32'h1);
      repeat (5) @(posedge sys_clk);
      check("sleep pins", {29'h0, out_enable, core_power_down, ref_power_down}, 32'h3);
      rdchk(12'h010, 32'h1, 1'b0);
      mode <= 2'd0;
      repeat (10) @(posedge sys_clk);
      check("drained", {31'h0, out_valid}, 32'h0);
      check("hold", 32'(hold_errs), 32'h0);
      check("moved", {31'h0, accepted > 100}, 32'h1);
      wake(WAKE);
      repeat (20) @(posedge sys_clk);
      lat(`APPC_PROC_LAT, 0, 8);
      apb(1'b1, 12'h00c, 32'h2);
      repeat (5) @(posedge sys_clk);
      check("standby pins", {29'h0, out_enable, core_power_down, ref_power_down}, 32'h6);
      wake(`APPC_CORE_WAKE_CYC);
      rst_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rdchk(12'h000, 32'h0, 1'b0);
      repeat (40) @(posedge sys_clk);
      lat(`APPC_BYPASS_LAT, 0, 8);
      summarize();
   end
   initial begin
      #300000;
      num_errors++;
      summarize();
   end
endmodule
bind appc_top appc_top_properties #(.FULL_WAKE_CYC(FULL_WAKE_CYC)) u_props (.sys_clk(sys_clk), .rst_n(rst_n),
   .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .raw_sample(raw_sample), .out_ready(out_ready),
   .out_data(out_data), .out_valid(out_valid), .out_enable(out_enable), .core_power_down(core_power_down),
   .ref_power_down(ref_power_down));
